// ---- rtl/ltds_sequencer.sv ----
// Purpose: discrete command sequencer and valve driver of a leak test instrument
// Assumes: all inputs synchronous to clk_in; routine timing is modelled by counters
// Notes:   stop overrides everything, including busy routines
`timescale 1ns/1ps

// Behaviour
// - all valves closed unless status opens them
// - vent opens vent, reservoir, reference rough
// - rough all closed; gross opens gross only
// - fine/hold reservoir+ref rough; cal reservoir+ref test
// - stop pulse moves system to vent
// - start steps rough, gross, then fine
// - controller holds enable level while in command
// - zero pulse zeroes; cal pulse calibrates
// - manual range pulses step exponent down/up
// - auto range keeps reading within display
// - hold input places system in hold
// - reject high while rate over threshold
// - emitter failure follows filament fault
// - ready while operating; not ready inverse
// - cal good reflects last calibration result
// - zeroing busy during whole zero routine
// - calibrating busy during whole calibration
// - discrete commands ignored without enable level
// - enable locks panel and serial changes
module ltds_sequencer #(
    parameter int STEP_CYC = ltds_pkg::STEP_CYCLES,
    parameter int ZERO_CYC = ltds_pkg::ZERO_CYCLES,
    parameter int CAL_CYC  = ltds_pkg::CAL_CYCLES
) (
    // clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     reset_n_in,
    // discrete commands
    input  wire ltds_pkg::ltds_pulse_type pulse_in,
    input  wire logic                     enable_in,
    input  wire logic                     auto_range_in,
    input  wire logic                     hold_in,
    // measurement side
    input  wire logic [15:0]              leak_rate_in,
    input  wire logic [15:0]              reject_level_in,
    input  wire logic                     filament_bad_in,
    input  wire logic                     cal_pass_in,
    // status outputs
    output logic                          reject_out,
    output logic                          emitter_fail_out,
    output logic                          ready_out,
    output logic                          not_ready_out,
    output logic                          cal_good_out,
    output logic                          zeroing_out,
    output logic                          calibrating_out,
    output logic                          local_lock_out,
    output logic [3:0]                    range_exp_out,
    output ltds_pkg::ltds_valve_type      valves_out
);
    import ltds_pkg::*;

    // refuse counts the counters cannot serve
    if (STEP_CYC < 1 || ZERO_CYC < 1 || CAL_CYC < 1) begin
        $error("counts must be at least one cycle");
    end

    localparam logic [15:0] RATE_HIGH = 16'hf000;
    localparam logic [15:0] RATE_LOW  = 16'h0100;
    localparam logic [3:0]  EXP_MAX   = 4'hf;
    localparam logic [3:0]  EXP_MIN   = 4'h0;

    ltds_state_type state_reg;
    ltds_state_type state_next;
    ltds_pulse_type pulse_prev_reg;
    ltds_pulse_type cmd;
    logic [31:0]    step_cnt_reg;
    logic [31:0]    busy_cnt_reg;
    logic           busy;
    logic           stop_cmd;
    logic           hold_prev_reg;
    logic           hold_cmd;

    function automatic ltds_valve_type valves_for(input ltds_state_type s);
        ltds_valve_type v;
        v = VALVES_CLOSED;
        unique case (s)
            LTDS_VENT: begin
                v.vent      = 1'b1;
                v.res_rough = 1'b1;
                v.ref_rough = 1'b1;
            end
            LTDS_ROUGH: begin
                v = VALVES_CLOSED;
            end
            LTDS_GROSS: begin
                v.gross = 1'b1;
            end
            LTDS_FINE, LTDS_HOLD: begin
                v.res_rough = 1'b1;
                v.ref_rough = 1'b1;
            end
            LTDS_CAL: begin
                v.res_rough = 1'b1;
                v.ref_test  = 1'b1;
            end
            default: v = VALVES_CLOSED;
        endcase
        return v;
    endfunction

    // edge detect, gated by enable level
    assign cmd      = enable_in ? (pulse_in & ~pulse_prev_reg) : '0;
    assign stop_cmd = cmd.stop;
    assign hold_cmd = enable_in && hold_in && !hold_prev_reg;
    assign busy     = zeroing_out || calibrating_out;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pulse_prev_reg <= '0;
            hold_prev_reg  <= 1'b0;
        end else begin
            pulse_prev_reg <= pulse_in;
            hold_prev_reg  <= hold_in;
        end
    end

    always_comb begin
        state_next = state_reg;
        if (stop_cmd) begin
            state_next = LTDS_VENT;
        end else if (!busy) begin
            if (hold_cmd) begin
                state_next = LTDS_HOLD;
            end else if (cmd.start) begin
                state_next = LTDS_ROUGH;
            end else if (cmd.cal) begin
                state_next = LTDS_CAL;
            end else if (state_reg == LTDS_CAL) begin
                // calibration over, resume fine test
                state_next = LTDS_FINE;
            end else if (step_cnt_reg == 32'(STEP_CYC - 1)) begin
                unique case (state_reg)
                    LTDS_ROUGH: state_next = LTDS_GROSS;
                    LTDS_GROSS: state_next = LTDS_FINE;
                    default:    state_next = state_reg;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg    <= LTDS_VENT;
            step_cnt_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                step_cnt_reg <= 32'h0;
            end else if (step_cnt_reg != 32'(STEP_CYC - 1)) begin
                step_cnt_reg <= step_cnt_reg + 32'h1;
            end
        end
    end

    // zero and calibration routines
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            zeroing_out     <= 1'b0;
            calibrating_out <= 1'b0;
            cal_good_out    <= 1'b0;
            busy_cnt_reg    <= 32'h0;
        end else if (stop_cmd) begin
            zeroing_out     <= 1'b0;
            calibrating_out <= 1'b0;
            busy_cnt_reg    <= 32'h0;
        end else if (zeroing_out) begin
            busy_cnt_reg <= busy_cnt_reg + 32'h1;
            if (busy_cnt_reg == 32'(ZERO_CYC - 1)) begin
                zeroing_out <= 1'b0;
            end
        end else if (calibrating_out) begin
            busy_cnt_reg <= busy_cnt_reg + 32'h1;
            if (busy_cnt_reg == 32'(CAL_CYC - 1)) begin
                calibrating_out <= 1'b0;
                cal_good_out    <= cal_pass_in;
            end
        end else if (cmd.zero) begin
            zeroing_out  <= 1'b1;
            busy_cnt_reg <= 32'h0;
        end else if (cmd.cal) begin
            calibrating_out <= 1'b1;
            busy_cnt_reg    <= 32'h0;
        end
    end

    // range exponent, manual or automatic
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            range_exp_out <= EXP_RESET;
        end else if (enable_in && auto_range_in) begin
            if (leak_rate_in > RATE_HIGH && range_exp_out != EXP_MAX) begin
                range_exp_out <= range_exp_out + 4'h1;
            end else if (leak_rate_in < RATE_LOW && range_exp_out != EXP_MIN) begin
                range_exp_out <= range_exp_out - 4'h1;
            end
        end else if (cmd.range_down && range_exp_out != EXP_MIN) begin
            range_exp_out <= range_exp_out - 4'h1;
        end else if (cmd.range_up && range_exp_out != EXP_MAX) begin
            range_exp_out <= range_exp_out + 4'h1;
        end
    end

    // status outputs and valves
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reject_out       <= 1'b0;
            emitter_fail_out <= 1'b0;
            ready_out        <= 1'b0;
            not_ready_out    <= 1'b1;
            local_lock_out   <= 1'b0;
            valves_out       <= VALVES_CLOSED;
        end else begin
            reject_out       <= leak_rate_in > reject_level_in;
            emitter_fail_out <= filament_bad_in;
            ready_out        <= !filament_bad_in;
            not_ready_out    <= filament_bad_in;
            local_lock_out   <= enable_in;
            valves_out       <= valves_for(state_next);
        end
    end

    a_stop_vent: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        stop_cmd |=> state_reg == LTDS_VENT)
        else $error("stop did not vent");
    a_stop_clears: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        stop_cmd |=> !zeroing_out && !calibrating_out)
        else $error("stop left a routine busy");
    a_ready_inverse: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ready_out != not_ready_out)
        else $error("not ready is not inverse of ready");
    a_valve_map: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $past(reset_n_in) |-> valves_out == valves_for(state_reg))
        else $error("valves disagree with status");
    a_vent_valves: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $past(reset_n_in) && state_reg == LTDS_VENT |-> valves_out == 5'h19)
        else $error("vent valves wrong");
    a_gross_only: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_reg == LTDS_GROSS |-> valves_out == 5'h04)
        else $error("gross valves wrong");
    a_cal_valves: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_reg == LTDS_CAL |-> valves_out == 5'h0a)
        else $error("cal valves wrong");
    a_rough_steps: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_reg == LTDS_ROUGH && step_cnt_reg == 32'(STEP_CYC - 1) && cmd == '0
        && !hold_cmd && !busy |=> state_reg == LTDS_GROSS)
        else $error("rough did not step to gross");
    a_no_enable: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !enable_in && state_reg != LTDS_CAL |=> $stable(state_reg) || state_reg == LTDS_GROSS
        || state_reg == LTDS_FINE)
        else $error("command taken without enable");
    a_cmd_gated: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !enable_in |-> cmd == '0 && !hold_cmd)
        else $error("command decoded without enable");
    a_reject_level: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $past(reset_n_in) |-> reject_out == $past(leak_rate_in > reject_level_in))
        else $error("reject wrong");
    a_emitter_fail: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $past(reset_n_in) |-> emitter_fail_out == $past(filament_bad_in))
        else $error("emitter failure wrong");
    a_lock_level: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $past(reset_n_in) |-> local_lock_out == $past(enable_in))
        else $error("lock does not follow enable");
    a_start_rough: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cmd.start && !stop_cmd && !busy && !hold_cmd |=> state_reg == LTDS_ROUGH)
        else $error("start did not rough");
    a_busy_block: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        busy && !stop_cmd && cmd.start
        |=> state_reg != LTDS_ROUGH || $past(state_reg) == LTDS_ROUGH)
        else $error("start taken while busy");
    a_hold_entry: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        hold_cmd && !stop_cmd && !busy |=> state_reg == LTDS_HOLD)
        else $error("hold not entered");
    a_single_cmd: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cmd.zero |=> !cmd.zero)
        else $error("pulse gave two commands");
    a_zero_start: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cmd.zero && !stop_cmd && !busy |=> zeroing_out)
        else $error("zero routine not started");
    a_zero_length: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        zeroing_out && busy_cnt_reg != 32'(ZERO_CYC - 1) && !stop_cmd |=> zeroing_out)
        else $error("zeroing ended early");
    a_cal_start: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cmd.cal && !cmd.zero && !stop_cmd && !busy |=> calibrating_out)
        else $error("calibration not started");
    a_cal_length: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        calibrating_out && busy_cnt_reg != 32'(CAL_CYC - 1) && !stop_cmd |=> calibrating_out)
        else $error("calibration ended early");
    a_cal_result: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        calibrating_out && busy_cnt_reg == 32'(CAL_CYC - 1) && !stop_cmd
        |=> cal_good_out == $past(cal_pass_in))
        else $error("cal good not updated");
    a_range_down: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cmd.range_down && !(enable_in && auto_range_in) && range_exp_out != EXP_MIN
        |=> range_exp_out == $past(range_exp_out) - 4'h1)
        else $error("range down not taken");
    a_range_up: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cmd.range_up && !cmd.range_down && !(enable_in && auto_range_in)
        && range_exp_out != EXP_MAX |=> range_exp_out == $past(range_exp_out) + 4'h1)
        else $error("range up not taken");
    a_auto_down: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        enable_in && auto_range_in && leak_rate_in < RATE_LOW && range_exp_out != EXP_MIN
        |=> range_exp_out == $past(range_exp_out) - 4'h1)
        else $error("auto range did not step down");

endmodule

// ---- rtl/ltds_pkg.sv ----
// Purpose: shared types and constants for the leak test discrete sequencer
// Assumes: 100 MHz system clock
// Notes:   valve vector order is vent, reservoir rough, gross, ref test, ref rough
package ltds_pkg;

    localparam int          CLK_MHZ        = 100;
    localparam int          STEP_TIME_US   = 1000;
    localparam int          STEP_CYCLES    = STEP_TIME_US * CLK_MHZ;
    localparam int          ZERO_TIME_US   = 2000;
    localparam int          ZERO_CYCLES    = ZERO_TIME_US * CLK_MHZ;
    localparam int          CAL_TIME_US    = 3000;
    localparam int          CAL_CYCLES     = CAL_TIME_US * CLK_MHZ;
    localparam int          EXP_WIDTH      = 4;
    localparam logic [3:0]  EXP_RESET      = 4'h8;
    localparam int          RATE_WIDTH     = 16;

    localparam int          VALVE_VENT_POS     = 4;
    localparam int          VALVE_RES_POS      = 3;
    localparam int          VALVE_GROSS_POS    = 2;
    localparam int          VALVE_REFTEST_POS  = 1;
    localparam int          VALVE_REFROUGH_POS = 0;

    typedef enum logic [5:0] {
        LTDS_VENT  = 6'h01,
        LTDS_ROUGH = 6'h02,
        LTDS_GROSS = 6'h04,
        LTDS_FINE  = 6'h08,
        LTDS_CAL   = 6'h10,
        LTDS_HOLD  = 6'h20
    } ltds_state_type;

    typedef struct packed {
        logic stop;
        logic start;
        logic zero;
        logic cal;
        logic range_down;
        logic range_up;
    } ltds_pulse_type;

    typedef struct packed {
        logic vent;
        logic res_rough;
        logic gross;
        logic ref_test;
        logic ref_rough;
    } ltds_valve_type;

    localparam ltds_valve_type VALVES_CLOSED = 5'h00;

endpackage

// ---- testbench/ltds_plc_model.sv ----
// Purpose: controller-side model that shapes discrete command pulses
// Assumes: one command at a time; the bench picks the command bit
// Notes:   short width stands in for the long pulse; lines low between pulses
`timescale 1ns/1ps
module ltds_plc_model #(
    parameter int PULSE_CYC = 4
) (
    // clock
    input  wire logic                clk_in,
    // request from bench
    input  wire logic                fire_in,
    input  wire logic [2:0]          sel_in,
    // discrete pulse lines
    output ltds_pkg::ltds_pulse_type pulse_out
);
    import ltds_pkg::*;

    logic [7:0] width_reg = 8'h00;
    logic [5:0] bits_reg  = 6'h00;

    // one high pulse of fixed width per request
    always_ff @(posedge clk_in) begin
        if (fire_in) begin
            bits_reg  <= 6'h01 << sel_in;
            width_reg <= 8'(PULSE_CYC);
        end else if (width_reg > 8'h01) begin
            width_reg <= width_reg - 8'h01;
        end else begin
            width_reg <= 8'h00;
            bits_reg  <= 6'h00;
        end
    end

    assign pulse_out = bits_reg;
endmodule

// ---- testbench/ltds_sequencer_tb.sv ----
// Purpose: self-checking bench for the leak test discrete sequencer
// Assumes: shortened step, zero and calibration counts
// Notes:   command selects: 5 stop, 4 start, 3 zero, 2 cal, 1 down, 0 up
`timescale 1ns/1ps
module ltds_sequencer_tb;
    import ltds_pkg::*;

    localparam int STEP = 12;
    localparam int ZERO = 20;
    localparam int CAL  = 16;
    localparam int PW   = 4;

    logic           clk_in, reset_n_in, enable_in, auto_range_in, hold_in;
    logic           fire, filament_bad_in, cal_pass_in;
    logic [2:0]     sel_in;
    logic [15:0]    leak_rate_in, reject_level_in;
    ltds_pulse_type pulse_in;
    logic           reject_out, emitter_fail_out, ready_out, not_ready_out;
    logic           cal_good_out, zeroing_out, calibrating_out, local_lock_out;
    logic [3:0]     range_exp_out;
    ltds_valve_type valves_out;
    int             n_errors = 0;
    int             compares = 0;

    ltds_plc_model #(.PULSE_CYC(PW)) ltds_plc_model_i (
        .clk_in(clk_in), .fire_in(fire), .sel_in(sel_in), .pulse_out(pulse_in));

    ltds_sequencer #(.STEP_CYC(STEP), .ZERO_CYC(ZERO), .CAL_CYC(CAL)) ltds_sequencer_i (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .pulse_in(pulse_in),
        .enable_in(enable_in), .auto_range_in(auto_range_in), .hold_in(hold_in),
        .leak_rate_in(leak_rate_in), .reject_level_in(reject_level_in),
        .filament_bad_in(filament_bad_in), .cal_pass_in(cal_pass_in),
        .reject_out(reject_out), .emitter_fail_out(emitter_fail_out),
        .ready_out(ready_out), .not_ready_out(not_ready_out),
        .cal_good_out(cal_good_out), .zeroing_out(zeroing_out),
        .calibrating_out(calibrating_out), .local_lock_out(local_lock_out),
        .range_exp_out(range_exp_out), .valves_out(valves_out));

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // request one command pulse and let it fall again
    task automatic pulse(input int sel);
        sel_in = sel[2:0];
        fire = 1'b1;
        cyc(1);
        fire = 1'b0;
        cyc(PW + 2);
    endtask

    task automatic wait_valves(input logic [4:0] exp, input int lim);
        for (int i = 0; i < lim && valves_out !== exp; i++) cyc(1);
        chk(16'(valves_out), 16'(exp));
    endtask

    task automatic wait_idle(input int lim);
        for (int i = 0; i < lim && (zeroing_out !== 1'b0 || calibrating_out !== 1'b0); i++)
            cyc(1);
        chk(16'({zeroing_out, calibrating_out}), 16'h0000);
    endtask

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    initial begin
        repeat (3000) @(posedge clk_in);
        n_errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 16'h0000, 16'h0001);
        wrap_up();
    end

    initial begin
        reset_n_in = 1'b0;
        enable_in = 1'b0;
        auto_range_in = 1'b0;
        hold_in = 1'b0;
        fire = 1'b0;
        sel_in = 3'h0;
        leak_rate_in = 16'h1000;
        reject_level_in = 16'h2000;
        filament_bad_in = 1'b0;
        cal_pass_in = 1'b1;
        repeat (10) @(posedge clk_in);
        #1;
        reset_n_in = 1'b1;
        cyc(3);
        chk(16'(valves_out), 16'h0019);
        chk(16'(range_exp_out), 16'(EXP_RESET));
        chk(16'({ready_out, not_ready_out}), 16'h0002);
        pulse(4);
        chk(16'(valves_out), 16'h0019);
        chk(16'(local_lock_out), 16'h0000);
        enable_in = 1'b1;
        cyc(2);
        chk(16'(local_lock_out), 16'h0001);
        pulse(4);
        chk(16'(valves_out), 16'h0000);
        wait_valves(5'h04, STEP + 4);
        wait_valves(5'h09, STEP + 4);
        cyc(STEP + 4);
        chk(16'(valves_out), 16'h0009);
        pulse(3);
        chk(16'(zeroing_out), 16'h0001);
        pulse(4);
        chk(16'({zeroing_out, valves_out}), 16'h0029);
        wait_idle(ZERO);
        chk(16'(valves_out), 16'h0009);
        pulse(2);
        chk(16'({calibrating_out, valves_out}), 16'h002a);
        wait_idle(CAL);
        chk(16'(cal_good_out), 16'h0001);
        wait_valves(5'h09, 4);
        cal_pass_in = 1'b0;
        pulse(2);
        wait_idle(CAL);
        chk(16'(cal_good_out), 16'h0000);
        pulse(2);
        pulse(5);
        chk(16'({calibrating_out, valves_out}), 16'h0019);
        hold_in = 1'b1;
        cyc(3);
        chk(16'(valves_out), 16'h0009);
        hold_in = 1'b0;
        pulse(1);
        chk(16'(range_exp_out), 16'h0007);
        pulse(0);
        pulse(0);
        chk(16'(range_exp_out), 16'h0009);
        auto_range_in = 1'b1;
        pulse(0);
        chk(16'(range_exp_out), 16'h0009);
        leak_rate_in = 16'h0050;
        cyc(3);
        chk(16'(range_exp_out), 16'h0006);
        leak_rate_in = 16'hf001;
        cyc(2);
        chk(16'(range_exp_out), 16'h0008);
        leak_rate_in = 16'h2001;
        cyc(2);
        chk(16'(reject_out), 16'h0001);
        leak_rate_in = 16'h2000;
        cyc(2);
        chk(16'(reject_out), 16'h0000);
        filament_bad_in = 1'b1;
        cyc(3);
        chk(16'({emitter_fail_out, ready_out, not_ready_out}), 16'h0005);
        reset_n_in = 1'b0;
        cyc(1);
        chk(16'(valves_out), 16'h0000);
        reset_n_in = 1'b1;
        cyc(2);
        chk(16'({valves_out, range_exp_out}), 16'h0198);
        wrap_up();
    end
endmodule
